// *** core/oie_pkg.sv ***
/*
 package for the oscillator interrupt-enable register pair: offsets, field
 positions, reset values, bus states.
 assumes a classic wishbone master with 32-bit data and byte selects.
*/
// Overview of operation
// - registers accept atomic 8, 16 and 32 bit accesses.
// - each byte and halfword of a register is reachable on its own.
// - writes to both enable registers are ignored while write protection is on.
// - clear view at 0x00, 32 bits, resets zero, writing one clears enable.
// - set view at 0x04, 32 bits, resets zero, writing one sets enable.
// - writing zero to any enable bit leaves it unchanged.
// - both views show one shared enable state.
// - bits 11,10,9,8,4,1,0 hold the seven source enables.
// - a source requests only while its enable and flag are both one.
// - flags set on status rising edge, cleared by writing one; one request line.
package oie_pkg;
   localparam int unsigned OIE_DW = 32;
   localparam int unsigned OIE_AW = 8;
   localparam logic [7:0] OIE_OFS_CLR = 8'h00;
   localparam logic [7:0] OIE_OFS_SET = 8'h04;
   localparam logic [7:0] OIE_OFS_FLAG = 8'h08;
   localparam logic [7:0] OIE_OFS_STAT = 8'h0c;
   localparam int unsigned OIE_NSRC = 7;
   localparam int unsigned OIE_BIT_RATIO = 11;
   localparam int unsigned OIE_BIT_LTO = 10;
   localparam int unsigned OIE_BIT_LCKF = 9;
   localparam int unsigned OIE_BIT_LCKR = 8;
   localparam int unsigned OIE_BIT_OSC48 = 4;
   localparam int unsigned OIE_BIT_FAIL = 1;
   localparam int unsigned OIE_BIT_XRDY = 0;
   localparam logic [31:0] OIE_IMPL_MASK = 32'h00000f13;
   localparam logic [31:0] OIE_RST_VAL = 32'h00000000;
   typedef enum logic [1:0] {
      OIE_IDLE = 2'b00,
      OIE_ACK = 2'b01
   } oie_bus_e;
endpackage

// *** core/oie_sync2.sv ***
/*
 two flip-flop synchroniser for one status level.
 assumes the level may change at any time relative to ref_clk_i.
*/
`timescale 1ns/1ps
module oie_sync2 (
   input wire logic ref_clk_i, // bus clock
   input wire logic sys_rst_i, // synchronous reset, high
   input wire logic async_i, // level from another domain
   output logic sync_o // synchronised level
);
   logic meta_q;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// *** core/oie_flag.sv ***
/*
 one sticky interrupt flag set by a rising edge of its synced status bit.
 assumes stat_i is already synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module oie_flag (
   input wire logic ref_clk_i, // bus clock
   input wire logic sys_rst_i, // synchronous reset, high
   input wire logic stat_i, // synced status level
   input wire logic clr_i, // one-cycle clear pulse
   output logic flag_o // sticky flag
);
   logic prev_q;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         prev_q <= 1'b0;
         flag_o <= 1'b0;
      end else begin
         prev_q <= stat_i;
         if (stat_i && !prev_q)
            flag_o <= 1'b1;
         else if (clr_i)
            flag_o <= 1'b0;
      end
   end
endmodule

// *** core/oie_regs.sv ***
/*
 interrupt-enable register pair of the oscillator controller with its flag
 register, a status view and the shared interrupt request.
 assumes a classic wishbone master on ref_clk_i and status levels from
 oscillator domains, which are synchronised here.
*/
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module oie_regs
   import oie_pkg::*;
(
   input wire logic ref_clk_i, // 50 MHz bus clock
   input wire logic sys_rst_i, // synchronous reset, high
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [oie_pkg::OIE_AW-1:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte selects
   input wire logic [oie_pkg::OIE_DW-1:0] wb_dat_i, // write data
   output logic [oie_pkg::OIE_DW-1:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic wr_protect_i, // peripheral_access_protection active
   input wire logic crystal_osc_ready_i, // status level
   input wire logic crystal_clock_failure_i, // status level
   input wire logic internal_osc_ready_i, // status level
   input wire logic pll_lock_rise_i, // status level
   input wire logic pll_lock_fall_i, // status level
   input wire logic pll_lock_timeout_i, // status level
   input wire logic pll_ratio_update_done_i, // status level
   output logic irq_o // shared interrupt request
);
   import oie_pkg::*;

   logic [OIE_DW-1:0] enable_q;
   logic [OIE_DW-1:0] enable_d;
   logic [OIE_DW-1:0] flags;
   logic [OIE_DW-1:0] stat;
   logic [OIE_DW-1:0] flag_clr;
   logic [OIE_DW-1:0] raw_stat;
   logic [OIE_DW-1:0] wmask;
   logic [OIE_DW-1:0] wbits;
   logic req;
   logic wr_go;
   logic prot_wr;
   oie_bus_e bus_q;
   logic [OIE_DW-1:0] stat_seen_q;
   logic [OIE_DW-1:0] stat_rise;

   always_comb begin
      raw_stat = '0;
      raw_stat[OIE_BIT_XRDY] = crystal_osc_ready_i;
      raw_stat[OIE_BIT_FAIL] = crystal_clock_failure_i;
      raw_stat[OIE_BIT_OSC48] = internal_osc_ready_i;
      raw_stat[OIE_BIT_LCKR] = pll_lock_rise_i;
      raw_stat[OIE_BIT_LCKF] = pll_lock_fall_i;
      raw_stat[OIE_BIT_LTO] = pll_lock_timeout_i;
      raw_stat[OIE_BIT_RATIO] = pll_ratio_update_done_i;
   end

   // one synchroniser and one flag per implemented bit
   genvar gi;
   generate
      for (gi = 0; gi < OIE_DW; gi++) begin : g_src
         if (OIE_IMPL_MASK[gi]) begin : g_impl
            oie_sync2 u_sync (
               .ref_clk_i(ref_clk_i),
               .sys_rst_i(sys_rst_i),
               .async_i(raw_stat[gi]),
               .sync_o(stat[gi])
            );
            oie_flag u_flag (
               .ref_clk_i(ref_clk_i),
               .sys_rst_i(sys_rst_i),
               .stat_i(stat[gi]),
               .clr_i(flag_clr[gi]),
               .flag_o(flags[gi])
            );
         end else begin : g_none
            assign stat[gi] = 1'b0;
            assign flags[gi] = 1'b0;
         end
      end
   endgenerate

   // single-cycle ack; ack drops the cycle after, so back-to-back strobes
   // see one idle cycle between accesses
   assign req = wb_cyc_i && wb_stb_i && (bus_q == OIE_IDLE);
   assign wr_go = req && wb_we_i;
   assign prot_wr = wr_protect_i;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         bus_q <= OIE_IDLE;
      end else begin
         case (bus_q)
            OIE_IDLE: if (req) bus_q <= OIE_ACK;
            OIE_ACK: bus_q <= OIE_IDLE;
            default: bus_q <= OIE_IDLE;
         endcase
      end
   end
   assign wb_ack_o = (bus_q == OIE_ACK);

   always_comb begin
      wmask = '0;
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
      wbits = wb_dat_i & wmask & OIE_IMPL_MASK;
   end

   always_comb begin
      enable_d = enable_q;
      flag_clr = '0;
      if (wr_go) begin
         case (wb_adr_i)
            OIE_OFS_CLR: if (!prot_wr) enable_d = enable_q & ~wbits;
            OIE_OFS_SET: if (!prot_wr) enable_d = enable_q | wbits;
            OIE_OFS_FLAG: flag_clr = wbits;
            default: enable_d = enable_q;
         endcase
      end
   end

   // one shared state behind both views
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i)
         enable_q <= OIE_RST_VAL;
      else
         enable_q <= enable_d;
   end

   // read data registered with the ack; unmapped offsets read zero and ack
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wb_dat_o <= '0;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            // both views read the shared enables
            OIE_OFS_CLR, OIE_OFS_SET: wb_dat_o <= enable_q & OIE_IMPL_MASK;
            OIE_OFS_FLAG: wb_dat_o <= flags;
            OIE_OFS_STAT: wb_dat_o <= stat;
            default: wb_dat_o <= '0;
         endcase
      end else if (bus_q == OIE_ACK) begin
         wb_dat_o <= '0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(enable_q & flags);
   end

   // helper copy of the synced status, only for checking flag edges
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i)
         stat_seen_q <= '0;
      else
         stat_seen_q <= stat;
   end
   assign stat_rise = stat & ~stat_seen_q;

   sequence s_set_wr;
      wr_go && !wr_protect_i && wb_adr_i == OIE_OFS_SET;
   endsequence

   sequence s_clr_wr;
      wr_go && !wr_protect_i && wb_adr_i == OIE_OFS_CLR;
   endsequence

   sequence s_read_en;
      req && !wb_we_i && (wb_adr_i == OIE_OFS_CLR || wb_adr_i == OIE_OFS_SET);
   endsequence

   a_irq_follows: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ##1 irq_o == $past(|(enable_q & flags)))
      else $error("irq does not follow enabled flags");

   a_irq_needs_en: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(irq_o) |-> $past(|(enable_q & flags)))
      else $error("irq rose without enabled flag");

   a_irq_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ((enable_q & flags) == '0) |=> !irq_o)
      else $error("irq high with no enabled flag");

   a_set_bits: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_set_wr |=> ((enable_q & $past(wbits)) == $past(wbits)))
      else $error("set write missed a bit");

   a_clr_bits: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_clr_wr |=> ((enable_q & $past(wbits)) == '0))
      else $error("clear write missed a bit");

   a_protect_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_go && wr_protect_i) |=> $stable(enable_q))
      else $error("protected write changed enables");

   a_zero_keeps: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_go && wb_adr_i == OIE_OFS_SET) |=> ((enable_q & ~$past(wbits)) == ($past(enable_q) & ~$past(wbits))))
      else $error("zero bit changed enable");

   a_clr_zero_keeps: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_go && wb_adr_i == OIE_OFS_CLR) |=> ((enable_q & ~$past(wbits)) == ($past(enable_q) & ~$past(wbits))))
      else $error("zero bit changed enable on clear");

   a_unimpl_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (enable_q & ~OIE_IMPL_MASK) == '0)
      else $error("unassigned enable bit set");

   a_unmapped_wr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_go && wb_adr_i != OIE_OFS_CLR && wb_adr_i != OIE_OFS_SET) |=> $stable(enable_q))
      else $error("write elsewhere changed enables");

   a_views_shared: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_read_en |=> wb_ack_o && wb_dat_o == $past(enable_q))
      else $error("enable view read mismatch");

   a_byte_lane: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (s_set_wr and (!wb_sel_i[1])) |=> $stable(enable_q[15:8]))
      else $error("unselected byte lane written");

   a_low_lane: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_go && !wr_protect_i && wb_adr_i == OIE_OFS_SET && !wb_sel_i[0]) |=> $stable(enable_q[7:0]))
      else $error("unselected low lane written");

   a_clr_lane: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_go && !wr_protect_i && wb_adr_i == OIE_OFS_CLR && !wb_sel_i[1]) |=> $stable(enable_q[15:8]))
      else $error("unselected lane cleared");

   a_ack_one: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not single cycle");

   a_ack_asked: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      wb_ack_o |-> $past(req))
      else $error("ack without request");

   a_dat_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !wb_ack_o |-> wb_dat_o == '0)
      else $error("read data outside ack");

   a_flag_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (req && !wb_we_i && wb_adr_i == OIE_OFS_FLAG) |=> wb_dat_o == $past(flags))
      else $error("flag view read mismatch");

   a_stat_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (req && !wb_we_i && wb_adr_i == OIE_OFS_STAT) |=> wb_dat_o == $past(stat))
      else $error("status view read mismatch");

   a_flag_on_rise: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      1'b1 |=> ((flags & $past(stat_rise)) == $past(stat_rise)))
      else $error("status rise did not set flag");

   a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      1'b1 |=> (($past(flags) & ~flags & ~$past(flag_clr)) == '0))
      else $error("flag fell without clear");
endmodule

// *** dv/tb.sv ***
/*
 self-checking bench for the oscillator interrupt-enable register pair.
 assumes oie_regs answers classic wishbone one cycle after the taking edge.
*/
`timescale 1ns/1ps
module tb;
   import oie_pkg::*;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, prot = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, st = 32'h0, rdat;
   logic [31:0] en_m = 32'h0, fl_m = 32'h0;
   logic ack, irq;
   int n_mismatch = 0, checks_done = 0;
   int srcs[7] = '{0, 1, 4, 8, 9, 10, 11};

   initial begin
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   oie_regs dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wr_protect_i(prot), .crystal_osc_ready_i(st[0]),
      .crystal_clock_failure_i(st[1]), .internal_osc_ready_i(st[4]), .pll_lock_rise_i(st[8]),
      .pll_lock_fall_i(st[9]), .pll_lock_timeout_i(st[10]), .pll_ratio_update_done_i(st[11]),
      .irq_o(irq));

   task automatic end_of_test();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         chk("ack timeout", 32'h1, 32'h0);
         end_of_test();
      end
   endtask

   // byte lanes masked, unassigned bits dropped, protection blocks enables only
   task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] r, x;
      xfer(1'b1, a, s, d, r);
      x = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & OIE_IMPL_MASK;
      if (a == OIE_OFS_CLR && !prot) en_m &= ~x;
      if (a == OIE_OFS_SET && !prot) en_m |= x;
      if (a == OIE_OFS_FLAG) fl_m &= ~x;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] r;
      xfer(1'b0, a, 4'hf, 32'h0, r);
      chk(name, exp, r);
   endtask

   task automatic chk_irq();
      repeat (3) @(posedge ref_clk_i);
      chk("irq", {31'h0, |(en_m & fl_m)}, {31'h0, irq});
   endtask

   initial begin
      int b;
      void'($urandom(32'h999b8fc1));
      repeat (20) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd(OIE_OFS_CLR, 32'h0, "clear view reset");
      rd(OIE_OFS_SET, 32'h0, "set view reset");
      chk("irq reset", 32'h0, {31'h0, irq});
      for (int i = 0; i < 60; i++) begin
         prot <= ($urandom % 4 == 0);
         wr(($urandom % 2) ? OIE_OFS_SET : OIE_OFS_CLR, 4'($urandom), $urandom);
         rd(OIE_OFS_CLR, en_m, "clear view");
         rd(OIE_OFS_SET, en_m, "set view");
      end
      prot <= 1'b0;
      wr(8'h40, 4'hf, 32'hffffffff);
      rd(8'h40, 32'h0, "unmapped read");
      wr(OIE_OFS_SET, 4'hf, 32'hffffffff);
      rd(OIE_OFS_SET, OIE_IMPL_MASK, "all enables");
      foreach (srcs[k]) begin
         b = srcs[k];
         st[b] <= 1'b1;
         repeat (6) @(posedge ref_clk_i);
         fl_m[b] = 1'b1;
         rd(OIE_OFS_FLAG, fl_m, "flag set");
         rd(OIE_OFS_STAT, st & OIE_IMPL_MASK, "status view");
         chk_irq();
         wr(OIE_OFS_CLR, 4'hf, 32'h1 << b);
         chk_irq();
         prot <= 1'b1;
         wr(OIE_OFS_SET, 4'hf, 32'h1 << b);
         chk_irq();
         prot <= 1'b0;
         wr(OIE_OFS_SET, 4'hf, 32'h1 << b);
         chk_irq();
         st[b] <= 1'b0;
         wr(OIE_OFS_FLAG, 4'hf, 32'h1 << b);
         rd(OIE_OFS_FLAG, fl_m, "flag clear");
         chk_irq();
      end
      end_of_test();
   end
endmodule
